// file: hw/aic_pkg.sv
// Package for the analog input control register bank.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per
// register, and byte address equal to four times the register index.
package aic_pkg;
  // Bus geometry
  localparam int AIC_ADDR_W = 16;
  localparam int AIC_DATA_W = 32;
  localparam int AIC_IDX_W = 14;
  localparam int AIC_IDX_LSB = 2;
  localparam logic [1:0] AIC_WORD_ALIGN = 2'h0;

  // Register indices, byte address is four times the index
  localparam logic [13:0] IDX_OFFSET_CAL = 14'h0701;
  localparam logic [13:0] IDX_ACC_RESET = 14'h073B;
  localparam logic [13:0] IDX_REF_SELECT = 14'h18A6;
  localparam logic [13:0] IDX_CM_BUFFER = 14'h18E3;
  localparam logic [13:0] IDX_DIODE_EXPORT = 14'h18E6;
  localparam logic [13:0] IDX_COUPLING = 14'h1908;
  localparam logic [13:0] IDX_FULL_SCALE = 14'h1910;
  localparam logic [13:0] IDX_SETTINGS_STATUS = 14'h1920;

  // Reset values
  localparam logic [7:0] RST_OFFSET_CAL = 8'h06;
  localparam logic [7:0] RST_ACC_RESET = 8'hB7;
  localparam logic [7:0] RST_REF_SELECT = 8'h00;
  localparam logic [7:0] RST_CM_BUFFER = 8'h00;
  localparam logic [7:0] RST_DIODE_EXPORT = 8'h00;
  localparam logic [7:0] RST_COUPLING = 8'h00;
  localparam logic [7:0] RST_FULL_SCALE = 8'h0D;

  // Writable bit masks, everything else is reserved and reads zero
  localparam logic [7:0] MSK_OFFSET_CAL = 8'hFF;
  localparam logic [7:0] MSK_ACC_RESET = 8'hFF;
  localparam logic [7:0] MSK_REF_SELECT = 8'h01;
  localparam logic [7:0] MSK_CM_BUFFER = 8'h7F;
  localparam logic [7:0] MSK_DIODE_EXPORT = 8'hFF;
  localparam logic [7:0] MSK_COUPLING = 8'h04;
  localparam logic [7:0] MSK_FULL_SCALE = 8'h0F;

  // Calibration and accumulator codes
  localparam logic [7:0] CAL_DISABLE = 8'h06;
  localparam logic [7:0] CAL_ENABLE = 8'h86;
  localparam logic [7:0] ACC_HOLD = 8'hB7;
  localparam logic [7:0] ACC_RUN_CAL_OFF = 8'h87;
  localparam logic [7:0] ACC_RUN_CAL_ON = 8'h37;

  // Field positions
  localparam int CM_EN_BIT = 6;
  localparam int CM_CODE_MSB = 5;
  localparam int DC_COUPLE_BIT = 2;
  localparam int REF_EXT_BIT = 0;
  localparam int FS_MSB = 3;
  localparam int DIODE_SRC_MSB = 7;
  localparam int DIODE_SRC_LSB = 4;
  localparam int DIODE_MODE_MSB = 1;

  // Diode source base codes, upper nibble of the export register
  localparam logic [3:0] DIODE_BASE_CENTRAL = 4'h0;
  localparam logic [3:0] DIODE_BASE_CHAN_A = 4'h4;
  localparam logic [3:0] DIODE_BASE_CHAN_B = 4'h5;

  // Decoded diode source
  typedef enum logic [1:0] {
    AIC_SRC_CENTRAL = 2'b00,
    AIC_SRC_CHAN_A = 2'b01,
    AIC_SRC_CHAN_B = 2'b10
  } aic_src_t;

  // Bus slave handshake states
  typedef enum logic {
    AIC_BUS_IDLE = 1'b0,
    AIC_BUS_ANSWER = 1'b1
  } aic_bus_state_t;

  // Full-scale codes that the front end supports
  localparam logic [3:0] FS_1V13 = 4'h8;
  localparam logic [3:0] FS_1V25 = 4'h9;
  localparam logic [3:0] FS_1V70 = 4'hD;
  localparam logic [3:0] FS_1V81 = 4'hE;
  localparam logic [3:0] FS_1V93 = 4'hF;
  localparam logic [3:0] FS_2V04 = 4'h0;

  // True when a byte address hits a given register index
  function automatic logic aic_hit(input logic [15:0] addr,
                                   input logic [13:0] idx);
    aic_hit = (addr[15:2] == idx) && (addr[1:0] == AIC_WORD_ALIGN);
  endfunction

  // True for the full-scale codes listed as supported
  function automatic logic aic_fs_ok(input logic [3:0] code);
    aic_fs_ok = (code == FS_1V13) || (code == FS_1V25) ||
                (code == FS_1V70) || (code == FS_1V81) ||
                (code == FS_1V93) || (code == FS_2V04);
  endfunction
endpackage

// file: hw/aic_bus_slave.sv
// Avalon-MM handshake for the register bank.
// Assumes the master holds read or write steady until waitrequest is low.
`timescale 1ns/100ps
module aic_bus_slave (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic read_in,
  input wire logic write_in,
  output logic waitrequest_out,
  output logic sample_out,
  output logic commit_out
);
  import aic_pkg::*;

  aic_bus_state_t state_q; // One wait state per access
  logic req; // Any request pending

  assign req = read_in | write_in;

  // First cycle stalls so read data can come from a flip-flop
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= AIC_BUS_IDLE;
    end else begin
      case (state_q)
        AIC_BUS_IDLE: begin
          if (req) begin
            state_q <= AIC_BUS_ANSWER;
          end
        end
        AIC_BUS_ANSWER: begin
          state_q <= AIC_BUS_IDLE;
        end
        default: begin
          state_q <= AIC_BUS_IDLE;
        end
      endcase
    end
  end

  // Handshake outputs are combinational by design
  assign waitrequest_out = req && (state_q == AIC_BUS_IDLE);
  assign sample_out = req && (state_q == AIC_BUS_IDLE);
  assign commit_out = req && (state_q == AIC_BUS_ANSWER);
endmodule

// file: hw/aic_acc_decode.sv
// Decoder for the calibration and accumulator reset codes.
// Purely combinational; the caller registers whatever it drives out.
`timescale 1ns/100ps
module aic_acc_decode (
  input wire logic [7:0] cal_code_in,
  input wire logic [7:0] acc_code_in,
  output logic cal_enable_out,
  output logic acc_hold_out,
  output logic code_ok_out,
  output logic pair_ok_out
);
  import aic_pkg::*;

  logic run_off; // Release code meant for calibration off
  logic run_on; // Release code meant for calibration on

  assign run_off = (acc_code_in == ACC_RUN_CAL_OFF);
  assign run_on = (acc_code_in == ACC_RUN_CAL_ON);
  assign cal_enable_out = (cal_code_in == CAL_ENABLE);
  // Only the two release codes let the accumulator run; an unknown
  // code keeps it held, which is the safe side
  assign acc_hold_out = !(run_off || run_on);
  assign code_ok_out = ((cal_code_in == CAL_ENABLE) ||
                        (cal_code_in == CAL_DISABLE)) &&
                       (run_off || run_on || (acc_code_in == ACC_HOLD));
  // Release code matches the calibration state
  assign pair_ok_out = cal_enable_out ? !run_off : !run_on;
endmodule

// file: hw/aic_regs.sv
// Register bank for reference and analog front end settings.
// Assumes one Avalon-MM master and one clock; outputs steer analog
// trims that sit outside this module.
//
// Behaviour
// - Calibration control resets 0x06; 0x86 enables
// - Accumulator reset register drives accumulator reset synchronously
// - Accumulator register resets 0xB7, holding reset
// - Writing 0x87 or 0x37 releases accumulator
// - Common-mode buffer: six-bit code plus enable bit
// - Diode export picks source and reference pin mode
// - Bit 2 selects dc or ac coupling
// - Full-scale field resets 0xD, accepts listed codes
`timescale 1ns/100ps
module aic_regs (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [aic_pkg::AIC_ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [aic_pkg::AIC_DATA_W-1:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [aic_pkg::AIC_DATA_W-1:0] readdata_out,
  output logic waitrequest_out,
  output logic cal_enable_out,
  output logic acc_hold_out,
  output logic ext_ref_out,
  output logic cm_buf_en_out,
  output logic [5:0] cm_buf_code_out,
  output aic_pkg::aic_src_t diode_src_out,
  output logic [1:0] vref_pin_mode_out,
  output logic dc_coupled_out,
  output logic [3:0] full_scale_code_out
);
  import aic_pkg::*;

  // Stored register contents, reserved bits held at zero
  logic [7:0] cal_q, cal_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] ref_q, ref_d;
  logic [7:0] cm_q, cm_d;
  logic [7:0] diode_q, diode_d;
  logic [7:0] couple_q, couple_d;
  logic [7:0] fs_q, fs_d;

  // Bus handshake strobes
  logic sample; // First cycle of a request
  logic commit; // Cycle in which waitrequest is low
  logic wr_en; // Write takes effect at this edge
  logic [7:0] wbyte; // Low byte lane of write data

  // Decoded register selects
  logic sel_cal, sel_acc, sel_ref, sel_cm;
  logic sel_diode, sel_couple, sel_fs, sel_stat;

  // Decoder results from the next-state values
  logic cal_en_d; // Calibration enabled after this edge
  logic acc_hold_d; // Accumulator held after this edge
  logic code_ok_d; // Calibration codes are listed ones
  logic pair_ok_d; // Release code matches calibration state

  // Status bits shown in the status register
  logic diode_ok; // Diode export code is a listed one
  logic fs_ok; // Full-scale code is a listed one
  logic [7:0] stat_byte;
  logic code_ok_q, pair_ok_q;

  // Read data, one byte wide, upper bits always zero
  logic [7:0] rd_byte;
  logic [7:0] rdata_q;

  aic_bus_slave u_bus (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .read_in(read_in),
    .write_in(write_in),
    .waitrequest_out(waitrequest_out),
    .sample_out(sample),
    .commit_out(commit)
  );

  // Register selects from the byte address
  always_comb begin
    sel_cal = aic_hit(address_in, IDX_OFFSET_CAL);
    sel_acc = aic_hit(address_in, IDX_ACC_RESET);
    sel_ref = aic_hit(address_in, IDX_REF_SELECT);
    sel_cm = aic_hit(address_in, IDX_CM_BUFFER);
    sel_diode = aic_hit(address_in, IDX_DIODE_EXPORT);
    sel_couple = aic_hit(address_in, IDX_COUPLING);
    sel_fs = aic_hit(address_in, IDX_FULL_SCALE);
    sel_stat = aic_hit(address_in, IDX_SETTINGS_STATUS);
  end

  // Only the low byte lane carries data; other lanes are ignored
  assign wr_en = commit && write_in && byteenable_in[0];
  assign wbyte = writedata_in[7:0];

  // Next values: masks drop reserved bits on write
  always_comb begin
    cal_d = cal_q;
    acc_d = acc_q;
    ref_d = ref_q;
    cm_d = cm_q;
    diode_d = diode_q;
    couple_d = couple_q;
    fs_d = fs_q;
    if (wr_en) begin
      if (sel_cal) begin
        cal_d = wbyte & MSK_OFFSET_CAL;
      end else if (sel_acc) begin
        acc_d = wbyte & MSK_ACC_RESET;
      end else if (sel_ref) begin
        ref_d = wbyte & MSK_REF_SELECT;
      end else if (sel_cm) begin
        cm_d = wbyte & MSK_CM_BUFFER;
      end else if (sel_diode) begin
        diode_d = wbyte & MSK_DIODE_EXPORT;
      end else if (sel_couple) begin
        couple_d = wbyte & MSK_COUPLING;
      end else if (sel_fs) begin
        fs_d = wbyte & MSK_FULL_SCALE;
      end
    end
  end

  // Calibration and accumulator registers with their reset codes
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cal_q <= RST_OFFSET_CAL;
      acc_q <= RST_ACC_RESET;
    end else begin
      cal_q <= cal_d;
      acc_q <= acc_d;
    end
  end

  // Reference, buffer and diode export registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ref_q <= RST_REF_SELECT;
      cm_q <= RST_CM_BUFFER;
      diode_q <= RST_DIODE_EXPORT;
    end else begin
      ref_q <= ref_d;
      cm_q <= cm_d;
      diode_q <= diode_d;
    end
  end

  // Input coupling and full-scale registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      couple_q <= RST_COUPLING;
      fs_q <= RST_FULL_SCALE;
    end else begin
      couple_q <= couple_d;
      fs_q <= fs_d;
    end
  end

  // Decode of the next calibration codes so outputs track the write
  aic_acc_decode u_dec (
    .cal_code_in(cal_d),
    .acc_code_in(acc_d),
    .cal_enable_out(cal_en_d),
    .acc_hold_out(acc_hold_d),
    .code_ok_out(code_ok_d),
    .pair_ok_out(pair_ok_d)
  );

  // Calibration enable and accumulator hold as flops; the hold is a
  // synchronous reset level for the accumulator, so no glitch escapes
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cal_enable_out <= 1'b0;
      acc_hold_out <= 1'b1;
      code_ok_q <= 1'b1;
      pair_ok_q <= 1'b1;
    end else begin
      cal_enable_out <= cal_en_d;
      acc_hold_out <= acc_hold_d;
      code_ok_q <= code_ok_d;
      pair_ok_q <= pair_ok_d;
    end
  end

  // Front end settings driven straight from next values
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ext_ref_out <= 1'b0;
      cm_buf_en_out <= 1'b0;
      cm_buf_code_out <= 6'h00;
      dc_coupled_out <= 1'b0;
      full_scale_code_out <= FS_1V70;
    end else begin
      ext_ref_out <= ref_d[REF_EXT_BIT];
      cm_buf_en_out <= cm_d[CM_EN_BIT];
      cm_buf_code_out <= cm_d[CM_CODE_MSB:0];
      dc_coupled_out <= couple_d[DC_COUPLE_BIT];
      full_scale_code_out <= fs_d[FS_MSB:0];
    end
  end

  // Diode source from the upper nibble; unlisted bases fall back to
  // the central diode so the pin never drives an undefined source
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      diode_src_out <= AIC_SRC_CENTRAL;
      vref_pin_mode_out <= 2'h0;
    end else begin
      vref_pin_mode_out <= diode_d[DIODE_MODE_MSB:0];
      if (diode_d[DIODE_SRC_MSB:DIODE_SRC_LSB] == DIODE_BASE_CHAN_A) begin
        diode_src_out <= AIC_SRC_CHAN_A;
      end else if (diode_d[DIODE_SRC_MSB:DIODE_SRC_LSB] ==
                   DIODE_BASE_CHAN_B) begin
        diode_src_out <= AIC_SRC_CHAN_B;
      end else begin
        diode_src_out <= AIC_SRC_CENTRAL;
      end
    end
  end

  // Listed-encoding checks shown to software
  assign diode_ok = (diode_q[3:2] == 2'h0) &&
                    ((diode_q[DIODE_SRC_MSB:DIODE_SRC_LSB] ==
                      DIODE_BASE_CENTRAL) ||
                     (diode_q[DIODE_SRC_MSB:DIODE_SRC_LSB] ==
                      DIODE_BASE_CHAN_A) ||
                     (diode_q[DIODE_SRC_MSB:DIODE_SRC_LSB] ==
                      DIODE_BASE_CHAN_B));
  assign fs_ok = aic_fs_ok(fs_q[FS_MSB:0]);
  assign stat_byte = {2'h0, pair_ok_q, code_ok_q, fs_ok, diode_ok,
                      acc_hold_out, cal_enable_out};

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    if (sel_cal) begin
      rd_byte = cal_q;
    end else if (sel_acc) begin
      rd_byte = acc_q;
    end else if (sel_ref) begin
      rd_byte = ref_q;
    end else if (sel_cm) begin
      rd_byte = cm_q;
    end else if (sel_diode) begin
      rd_byte = diode_q;
    end else if (sel_couple) begin
      rd_byte = couple_q;
    end else if (sel_fs) begin
      rd_byte = fs_q;
    end else if (sel_stat) begin
      rd_byte = stat_byte;
    end
  end

  // Read data captured in the stall cycle, stands until the next read
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else if (sample && read_in) begin
      rdata_q <= rd_byte;
    end
  end

  assign readdata_out = {24'h000000, rdata_q};

  // Checks on the write path to each output except ext_ref_out
  AST_CAL_ON: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_en && sel_cal && (wbyte == CAL_ENABLE) |=> cal_enable_out)
    else $error("calibration not enabled by 0x86");

  AST_CAL_OFF: assert property (@(posedge clock_in)
    disable iff (rst_in)
    wr_en && sel_cal && (wbyte == CAL_DISABLE) |=> !cal_enable_out)
    else $error("calibration not disabled by 0x06");

  AST_ACC_HOLD: assert property (@(posedge clock_in)
    disable iff (rst_in)
    wr_en && sel_acc && (wbyte == ACC_HOLD) |=> acc_hold_out)
    else $error("accumulator not held by 0xB7");

  AST_ACC_RUN: assert property (@(posedge clock_in)
    disable iff (rst_in)
    wr_en && sel_acc &&
    ((wbyte == ACC_RUN_CAL_OFF) || (wbyte == ACC_RUN_CAL_ON))
    |=> !acc_hold_out)
    else $error("accumulator not released");

  AST_ACC_STABLE: assert property (@(posedge clock_in)
    disable iff (rst_in)
    !(wr_en && sel_acc) |=> $stable(acc_hold_out))
    else $error("accumulator reset moved without a write");

  AST_CM_WRITE: assert property (@(posedge clock_in)
    disable iff (rst_in)
    wr_en && sel_cm |=> (cm_buf_en_out == $past(wbyte[CM_EN_BIT])) &&
    (cm_buf_code_out == $past(wbyte[CM_CODE_MSB:0])))
    else $error("buffer setting does not follow write");

  AST_DIODE_B: assert property (@(posedge clock_in)
    disable iff (rst_in)
    wr_en && sel_diode && (wbyte[7:4] == DIODE_BASE_CHAN_B)
    |=> (diode_src_out == AIC_SRC_CHAN_B) &&
    (vref_pin_mode_out == $past(wbyte[1:0])))
    else $error("channel B diode export wrong");

  // Channel A base must steer the source, whatever the pin mode
  AST_DIODE_A: assert property (@(posedge clock_in)
    disable iff (rst_in)
    wr_en && sel_diode && (wbyte[7:4] == DIODE_BASE_CHAN_A)
    |=> diode_src_out == AIC_SRC_CHAN_A)
    else $error("channel A diode export wrong");

  AST_COUPLE: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_en && sel_couple |=> dc_coupled_out == $past(wbyte[DC_COUPLE_BIT]))
    else $error("coupling bit does not follow write");

  AST_FS_WRITE: assert property (@(posedge clock_in)
    disable iff (rst_in)
    wr_en && sel_fs |=> full_scale_code_out == $past(wbyte[3:0]))
    else $error("full-scale code does not follow write");

  AST_RESERVED: assert property (@(posedge clock_in)
    disable iff (rst_in)
    commit && read_in && sel_couple
    |-> (readdata_out[7:3] == 5'h00) && (readdata_out[1:0] == 2'h0))
    else $error("reserved coupling bits read nonzero");

  AST_WAIT_ONE: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(read_in) |-> waitrequest_out ##1 !waitrequest_out)
    else $error("read not answered after one wait state");

  // Main scenarios
  CV_CAL_RUN: cover property (@(posedge clock_in) disable iff (rst_in)
    cal_enable_out && !acc_hold_out);
  CV_DIODE_A: cover property (@(posedge clock_in) disable iff (rst_in)
    diode_src_out == AIC_SRC_CHAN_A);
  CV_STAT_READ: cover property (@(posedge clock_in) disable iff (rst_in)
    commit && read_in && sel_stat);
  // Software puts the accumulator back into hold
  CV_ACC_REHOLD: cover property (@(posedge clock_in) disable iff (rst_in)
    wr_en && sel_acc && (wbyte == ACC_HOLD));
  // A write that is answered but lands nowhere
  CV_LANE_OFF: cover property (@(posedge clock_in) disable iff (rst_in)
    commit && write_in && !byteenable_in[0]);
endmodule

// file: tb/aic_regs_tb.sv
// Self-checking bench for the analog input control register bank.
// Assumes aic_pkg and aic_regs are compiled first; the bench is the
// only Avalon-MM master and keeps a shadow of every writable register.
`timescale 1ns/100ps
module aic_regs_tb;
  import aic_pkg::*;
  // One table row: register index, data written, value read back
  typedef struct packed {
    logic [13:0] idx;
    logic [7:0] wd;
    logic [7:0] rx;
  } aic_row_t;
  logic clock_in;
  logic rst_in;
  logic [15:0] address_in;
  logic read_in;
  logic write_in;
  logic [31:0] writedata_in;
  logic [3:0] byteenable_in;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic cal_enable_out;
  logic acc_hold_out;
  logic ext_ref_out;
  logic cm_buf_en_out;
  logic [5:0] cm_buf_code_out;
  aic_src_t diode_src_out;
  logic [1:0] vref_pin_mode_out;
  logic dc_coupled_out;
  logic [3:0] full_scale_code_out;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] got;
  // Register map in shadow order, with documented reset values
  logic [13:0] reg_idx [7] = '{IDX_OFFSET_CAL, IDX_ACC_RESET,
    IDX_REF_SELECT, IDX_CM_BUFFER, IDX_DIODE_EXPORT, IDX_COUPLING,
    IDX_FULL_SCALE};
  logic [7:0] rst_v [7] = '{8'h06, 8'hB7, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h0D};
  logic [7:0] sh [7];
  // Ordinary cases; reserved bits are set on purpose and must read zero
  aic_row_t rows [31] = '{
    '{IDX_OFFSET_CAL, 8'h86, 8'h86}, '{IDX_ACC_RESET, 8'h37, 8'h37},
    '{IDX_ACC_RESET, 8'h87, 8'h87}, '{IDX_OFFSET_CAL, 8'h06, 8'h06},
    '{IDX_ACC_RESET, 8'hB7, 8'hB7}, '{IDX_REF_SELECT, 8'hFF, 8'h01},
    '{IDX_REF_SELECT, 8'h00, 8'h00}, '{IDX_CM_BUFFER, 8'hFF, 8'h7F},
    '{IDX_CM_BUFFER, 8'h55, 8'h55}, '{IDX_CM_BUFFER, 8'h2A, 8'h2A},
    '{IDX_DIODE_EXPORT, 8'h01, 8'h01}, '{IDX_DIODE_EXPORT, 8'h02, 8'h02},
    '{IDX_DIODE_EXPORT, 8'h03, 8'h03}, '{IDX_DIODE_EXPORT, 8'h40, 8'h40},
    '{IDX_DIODE_EXPORT, 8'h41, 8'h41}, '{IDX_DIODE_EXPORT, 8'h42, 8'h42},
    '{IDX_DIODE_EXPORT, 8'h43, 8'h43}, '{IDX_DIODE_EXPORT, 8'h50, 8'h50},
    '{IDX_DIODE_EXPORT, 8'h51, 8'h51}, '{IDX_DIODE_EXPORT, 8'h52, 8'h52},
    '{IDX_DIODE_EXPORT, 8'h53, 8'h53}, '{IDX_DIODE_EXPORT, 8'h00, 8'h00},
    '{IDX_COUPLING, 8'hFF, 8'h04}, '{IDX_COUPLING, 8'hFB, 8'h00},
    '{IDX_FULL_SCALE, 8'hF8, 8'h08}, '{IDX_FULL_SCALE, 8'hF9, 8'h09},
    '{IDX_FULL_SCALE, 8'hFE, 8'h0E}, '{IDX_FULL_SCALE, 8'hFF, 8'h0F},
    '{IDX_FULL_SCALE, 8'hF0, 8'h00}, '{IDX_FULL_SCALE, 8'hFD, 8'h0D},
    '{14'h0000, 8'hFF, 8'h00}};

  aic_regs aic_regs_i (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .address_in(address_in),
    .read_in(read_in),
    .write_in(write_in),
    .writedata_in(writedata_in),
    .byteenable_in(byteenable_in),
    .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out),
    .cal_enable_out(cal_enable_out),
    .acc_hold_out(acc_hold_out),
    .ext_ref_out(ext_ref_out),
    .cm_buf_en_out(cm_buf_en_out),
    .cm_buf_code_out(cm_buf_code_out),
    .diode_src_out(diode_src_out),
    .vref_pin_mode_out(vref_pin_mode_out),
    .dc_coupled_out(dc_coupled_out),
    .full_scale_code_out(full_scale_code_out)
  );

  // 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // Counts a comparison and reports a mismatch at once
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // One Avalon transfer; the request is held until waitrequest is low
  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [7:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    @(posedge clock_in);
    address_in <= a;
    writedata_in <= {24'h0, wd};
    byteenable_in <= be;
    if (wr) begin
      write_in <= 1'b1;
    end else begin
      read_in <= 1'b1;
    end
    // Waitrequest is looked at mid-cycle, where it has settled; a stuck
    // one is caught by the watchdog
    do begin
      @(negedge clock_in);
    end while (waitrequest_out !== 1'b0);
    // The transfer completes at the next rising edge
    @(posedge clock_in);
    rd = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask

  // Shadow slot of a register index, -1 when unmapped
  function automatic int slot(input logic [13:0] i);
    for (int k = 0; k < 7; k++) begin
      if (reg_idx[k] == i) begin
        return k;
      end
    end
    return -1;
  endfunction

  // Setting outputs against what the shadow registers imply
  task automatic check_outputs();
    logic [1:0] es;
    es = (sh[4][7:4] == 4'h4) ? 2'h1 : (sh[4][7:4] == 4'h5) ? 2'h2 : 2'h0;
    check("cal_en", {31'h0, sh[0] == 8'h86}, {31'h0, cal_enable_out});
    check("acc_hold", {31'h0, !(sh[1] == 8'h87 || sh[1] == 8'h37)},
          {31'h0, acc_hold_out});
    check("ext_ref", {31'h0, sh[2][0]}, {31'h0, ext_ref_out});
    check("cm_buf_en", {31'h0, sh[3][6]}, {31'h0, cm_buf_en_out});
    check("cm_code", {26'h0, sh[3][5:0]}, {26'h0, cm_buf_code_out});
    check("diode_src", {30'h0, es}, 32'(diode_src_out));
    check("pin_mode", {30'h0, sh[4][1:0]}, {30'h0, vref_pin_mode_out});
    check("dc_coupled", {31'h0, sh[5][2]}, {31'h0, dc_coupled_out});
    check("fs", {28'h0, sh[6][3:0]}, {28'h0, full_scale_code_out});
  endtask

  // Reads every writable register back and compares with the shadow
  task automatic read_all();
    logic [31:0] rd;
    for (int k = 0; k < 7; k++) begin
      bus(1'b0, {reg_idx[k], 2'h0}, 8'h00, 4'hF, rd);
      check("register", {24'h0, sh[k]}, rd);
    end
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog; the full sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    $display("unexpected timeout: expected done, seen running");
    results();
  end

  // Main sequence
  initial begin
    rst_in = 1'b1;
    address_in = 16'h0000;
    read_in = 1'b0;
    write_in = 1'b0;
    writedata_in = 32'h0000_0000;
    byteenable_in = 4'hF;
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    sh = rst_v;
    read_all();
    check_outputs();
    // Status after reset: held, all codes listed, release matches
    bus(1'b0, {IDX_SETTINGS_STATUS, 2'h0}, 8'h00, 4'hF, got);
    check("status", 32'h0000_003E, got);
    $display("test reset values done");
    // Table of ordinary writes, each followed by a read back
    foreach (rows[r]) begin
      bus(1'b1, {rows[r].idx, 2'h0}, rows[r].wd, 4'hF, got);
      bus(1'b0, {rows[r].idx, 2'h0}, 8'h00, 4'hF, got);
      check("readback", {24'h0, rows[r].rx}, got);
      if (slot(rows[r].idx) >= 0) begin
        sh[slot(rows[r].idx)] = rows[r].rx;
      end
      check_outputs();
    end
    $display("test table done");
    // Write with byte lane 0 disabled must leave the register alone
    bus(1'b1, {IDX_CM_BUFFER, 2'h0}, 8'h41, 4'hE, got);
    // Misaligned write is refused, misaligned read returns zero
    bus(1'b1, {IDX_CM_BUFFER, 2'h2}, 8'h41, 4'hF, got);
    bus(1'b0, {IDX_CM_BUFFER, 2'h2}, 8'h00, 4'hF, got);
    check("misaligned read", 32'h0, got);
    read_all();
    check_outputs();
    $display("test refused writes done");
    // Accumulator release shows in the cycle after the write edge
    check("acc_hold before write", 32'h1, {31'h0, acc_hold_out});
    bus(1'b1, {IDX_ACC_RESET, 2'h0}, 8'h87, 4'hF, got);
    @(negedge clock_in);
    check("acc_hold after write", 32'h0, {31'h0, acc_hold_out});
    sh[1] = 8'h87;
    // Released with calibration off: codes listed and matching
    bus(1'b0, {IDX_SETTINGS_STATUS, 2'h0}, 8'h00, 4'hF, got);
    check("status released", 32'h0000_003C, got);
    // Back to the hold code re-asserts the synchronous reset
    bus(1'b1, {IDX_ACC_RESET, 2'h0}, 8'hB7, 4'hF, got);
    @(posedge clock_in);
    check("acc_hold rehold", 32'h1, {31'h0, acc_hold_out});
    sh[1] = 8'hB7;
    $display("test accumulator timing done");
    // Reset in mid-run after loading non-default settings
    bus(1'b1, {IDX_OFFSET_CAL, 2'h0}, 8'h86, 4'hF, got);
    bus(1'b1, {IDX_FULL_SCALE, 2'h0}, 8'h08, 4'hF, got);
    bus(1'b1, {IDX_CM_BUFFER, 2'h0}, 8'h7F, 4'hF, got);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    sh = rst_v;
    check_outputs();
    read_all();
    bus(1'b0, {IDX_SETTINGS_STATUS, 2'h0}, 8'h00, 4'hF, got);
    check("status after reset", 32'h0000_003E, got);
    $display("test mid-run reset done");
    results();
  end
endmodule
